//--- eabc_pkg.sv
// package: register map, reset values and field layout of the external area bus configuration
package eabc_pkg;

    // ************************************************************
    // register map: word indices, byte address is four times the index
    // ************************************************************
    localparam logic [15:0] ADDR_AREA_BUS_WIDTH_CTRL    = 16'hfed0;
    localparam logic [15:0] ADDR_AREA_ACCESS_STATE_CTRL = 16'hfed1;
    localparam logic [15:0] ADDR_AREA_WAIT_COUNT_HIGH   = 16'hfed2;
    localparam logic [15:0] ADDR_AREA_WAIT_COUNT_LOW    = 16'hfed3;
    localparam logic [15:0] ADDR_BUS_CTRL_HIGH          = 16'hfed4;
    localparam logic [15:0] ADDR_BUS_CTRL_LOW           = 16'hfed5;
    localparam logic [15:0] ADDR_STATUS                 = 16'hfed8;
    localparam int          REG_COUNT                   = 6;
    localparam int          AREA_COUNT                  = 8;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_WIDTH_WIDE     = 8'h00;
    localparam logic [7:0] RST_WIDTH_NARROW   = 8'hff;
    localparam logic [7:0] RST_ACCESS_STATE   = 8'hff;
    localparam logic [7:0] RST_WAIT_COUNT     = 8'hff;
    localparam logic [7:0] RST_BUS_CTRL_HIGH  = 8'hd0;
    localparam logic [7:0] RST_BUS_CTRL_LOW   = 8'h3c;

    // ************************************************************
    // operating modes and fields
    // ************************************************************
    localparam logic [2:0] MODE_WIDE_RESET    = 3'h4;
    localparam int         WAIT_FIELD_WIDTH   = 2;
    localparam logic [1:0] HTRANS_NONSEQ      = 2'h2;
    localparam logic [1:0] HTRANS_SEQ         = 2'h3;

    // bus slave phase
    typedef enum logic [0:0] {
        EABC_IDLE  = 1'b0,
        EABC_WRITE = 1'b1
    } eabc_phase_t;

endpackage : eabc_pkg

//--- eabc_area_decode.sv
// module: per-area access shaping for the external access sequencer
`timescale 1ns/1ps
`default_nettype none
module eabc_area_decode
    import eabc_pkg::*;
(
    input  wire logic [7:0] widthBits,
    input  wire logic [7:0] stateBits,
    input  wire logic [15:0] waitBits,
    input  wire logic [2:0] area,
    input  wire logic       normalMode,
    input  wire logic       internalSpace,
    output logic            areaByteWide,
    output logic            areaThreeState,
    output logic [1:0]      areaWaitCount
);

    // ************************************************************
    // area select and per-area decode
    // ************************************************************
    logic [2:0] effArea;

    // normal mode collapses external space onto area 0
    always_comb begin
        effArea = normalMode ? 3'h0 : area;
        areaByteWide   = internalSpace ? 1'b0 : widthBits[effArea];
        areaThreeState = internalSpace ? 1'b0 : stateBits[effArea];
        // waits only where three-state access is chosen
        if (areaThreeState) begin
            areaWaitCount = waitBits[effArea*WAIT_FIELD_WIDTH +: WAIT_FIELD_WIDTH];
        end else begin
            areaWaitCount = 2'h0;
        end
    end

endmodule : eabc_area_decode
`default_nettype wire

//--- eabc_regs.sv
// module: external area bus configuration register bank with AHB-Lite slave
//
// Operation
// - An area width bit of 0 gives 16-bit external access, 1 gives 8-bit access.
// - Power-on reset or hardware standby loads the width register with all ones, or zeros in mode 4.
// - Width and state registers keep their contents through manual reset and software standby.
// - On-chip memory and internal registers use their fixed width whatever the width bits say.
// - An area state bit of 0 gives 2-state access without waits, 1 gives 3-state with waits.
// - On-chip memory and internal registers use their fixed state count whatever the state bits say.
// - Power-on reset or hardware standby sets the state register to all ones.
// - In normal mode only the area 0 width bit matters.
// - In normal mode only the area 0 state bit matters.
// - Six byte registers are decoded at consecutive word indices on address bits 17 to 2.
// - A 3-state area inserts 0 to 3 program waits per its 2-bit wait field.
`timescale 1ns/1ps
`default_nettype none
module eabc_regs
    import eabc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        hardwareStandbyn,
    input  wire logic [2:0]  operatingMode,
    input  wire logic        normalMode,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [2:0]  accessArea,
    input  wire logic        accessInternal,
    input  wire logic        extWaitRequest,
    output logic             areaByteWide,
    output logic             areaThreeState,
    output logic [1:0]      areaWaitCount,
    output logic             waitRequestAccepted,
    output logic [7:0]       busCtrlHigh,
    output logic [7:0]       busCtrlLow
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [7:0]  widthReg;
        logic [7:0]  stateReg;
        logic [7:0]  waitHigh;
        logic [7:0]  waitLow;
        logic [7:0]  busHigh;
        logic [7:0]  busLow;
        eabc_phase_t phase;
        logic [15:0] wrAddr;
        logic [31:0] rdata;
        logic        waitSync1;
        logic        waitSync2;
        logic        waitAccepted;
        logic        misuseFlag;
    } eabc_state_t;

    eabc_state_t st;
    eabc_state_t next_st;
    logic        addrPhase;
    logic [15:0] lowAddr;
    logic [7:0]  selByte;
    logic [7:0]  rdByte;

    // ************************************************************
    // helpers
    // ************************************************************
    // pick the byte lane that carries an address
    function automatic logic [7:0] laneOf(input logic [31:0] word, input logic [1:0] lane);
        laneOf = word[lane*8 +: 8];
    endfunction : laneOf

    // power-on width value depends on operating mode
    function automatic logic [7:0] widthResetFor(input logic [2:0] mode);
        widthResetFor = (mode == MODE_WIDE_RESET) ? RST_WIDTH_WIDE : RST_WIDTH_NARROW;
    endfunction : widthResetFor

    // register read mux on the lower address bits
    function automatic logic [7:0] readReg(input eabc_state_t s, input logic [15:0] a);
        unique case (a)
            ADDR_AREA_BUS_WIDTH_CTRL:    readReg = s.widthReg;
            ADDR_AREA_ACCESS_STATE_CTRL: readReg = s.stateReg;
            ADDR_AREA_WAIT_COUNT_HIGH:   readReg = s.waitHigh;
            ADDR_AREA_WAIT_COUNT_LOW:    readReg = s.waitLow;
            ADDR_BUS_CTRL_HIGH:          readReg = s.busHigh;
            ADDR_BUS_CTRL_LOW:           readReg = s.busLow;
            ADDR_STATUS:                 readReg = {7'h00, s.misuseFlag};
            default:                     readReg = 8'h00;
        endcase
    endfunction : readReg

    // ************************************************************
    // bus decode
    // ************************************************************
    assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    assign lowAddr   = haddr[17:2];                 // word index of the access
    assign rdByte    = readReg(st, lowAddr);
    assign selByte   = laneOf(hwdata, 2'h0);        // each register owns lane 0 of its word

    // next state
    always_comb begin
        next_st = st;
        next_st.waitSync1 = extWaitRequest;
        next_st.waitSync2 = st.waitSync1;
        // outside wait honoured only on 3-state areas
        next_st.waitAccepted = st.waitSync2 && areaThreeState;
        if (st.waitSync2 && !areaThreeState) begin
            next_st.misuseFlag = 1'b1;
        end
        // data phase of a write stores the addressed byte
        if (st.phase == EABC_WRITE) begin
            unique case (st.wrAddr)
                ADDR_AREA_BUS_WIDTH_CTRL:    next_st.widthReg = selByte;
                ADDR_AREA_ACCESS_STATE_CTRL: next_st.stateReg = selByte;
                ADDR_AREA_WAIT_COUNT_HIGH:   next_st.waitHigh = selByte;
                ADDR_AREA_WAIT_COUNT_LOW:    next_st.waitLow  = selByte;
                ADDR_BUS_CTRL_HIGH:          next_st.busHigh  = selByte;
                ADDR_BUS_CTRL_LOW:           next_st.busLow   = selByte;
                ADDR_STATUS:                 next_st.misuseFlag = st.misuseFlag
                                                 & ~selByte[0] | (st.waitSync2 & ~areaThreeState);
                default:                     next_st.busLow   = st.busLow;
            endcase
        end
        next_st.phase = EABC_IDLE;
        if (addrPhase) begin
            next_st.phase  = hwrite ? EABC_WRITE : EABC_IDLE;
            next_st.wrAddr = lowAddr;
            // byte sits in lane 0 of its own word, upper lanes read zero
            next_st.rdata  = {24'h00_0000, rdByte};
        end
        // power-on reset / hardware standby only; manual reset not seen here
        if (!resetn || !hardwareStandbyn) begin
            next_st.widthReg = widthResetFor(operatingMode);
            next_st.stateReg = RST_ACCESS_STATE;
            next_st.waitHigh = RST_WAIT_COUNT;
            next_st.waitLow  = RST_WAIT_COUNT;
            next_st.busHigh  = RST_BUS_CTRL_HIGH;
            next_st.busLow   = RST_BUS_CTRL_LOW;
        end
        if (!resetn) begin
            next_st.phase        = EABC_IDLE;
            next_st.wrAddr       = 16'h0000;
            next_st.rdata        = 32'h0000_0000;
            next_st.waitSync1    = 1'b0;
            next_st.waitSync2    = 1'b0;
            next_st.waitAccepted = 1'b0;
            next_st.misuseFlag   = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clock) begin
        st <= next_st;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign hreadyout           = 1'b1;   // zero wait states
    assign hresp               = 1'b0;   // always OKAY
    assign hrdata              = st.rdata;
    assign busCtrlHigh         = st.busHigh;
    assign busCtrlLow          = st.busLow;
    assign waitRequestAccepted = st.waitAccepted;

    // per-area settings to the sequencer
    eabc_area_decode u_decode (
        .widthBits      (st.widthReg),
        .stateBits      (st.stateReg),
        .waitBits       ({st.waitHigh, st.waitLow}),
        .area           (accessArea),
        .normalMode     (normalMode),
        .internalSpace  (accessInternal),
        .areaByteWide   (areaByteWide),
        .areaThreeState (areaThreeState),
        .areaWaitCount  (areaWaitCount)
    );

endmodule : eabc_regs
`default_nettype wire

//--- eabc_regs_monitor.sv
// checker: bus and sequencer assertions for the external area bus configuration
`timescale 1ns/1ps
`default_nettype none
module eabc_regs_monitor
    import eabc_pkg::*;
(
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic        hardwareStandbyn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        accessInternal,
    input wire logic        extWaitRequest,
    input wire logic        areaByteWide,
    input wire logic        areaThreeState,
    input wire logic [1:0]  areaWaitCount,
    input wire logic        waitRequestAccepted,
    input wire logic [7:0]  busCtrlHigh,
    input wire logic [7:0]  busCtrlLow
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    logic       rdPend;
    logic       rdMapped;
    // remember the address phase of each read
    always_ff @(posedge clock) begin
        rdPend   <= hsel && hready && htrans[1] && !hwrite;
        rdMapped <= haddr[17:2] inside {[ADDR_AREA_BUS_WIDTH_CTRL:ADDR_BUS_CTRL_LOW], ADDR_STATUS};
    end
    chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
    chk_int_width: assert property (accessInternal |-> !areaByteWide)
        else $error("internal access narrowed");
    chk_int_state: assert property (accessInternal |-> !areaThreeState && areaWaitCount == 2'h0)
        else $error("internal access slowed");
    chk_wait_gated: assert property (!areaThreeState |-> areaWaitCount == 2'h0)
        else $error("waits on two-state access");
    chk_wait_cause: assert property (waitRequestAccepted |-> $past(extWaitRequest, 3) && $past(areaThreeState))
        else $error("wait accepted without cause");
    chk_wait_taken: assert property (extWaitRequest [*3] ##0 areaThreeState |=> waitRequestAccepted)
        else $error("wait request dropped");
    chk_reset_ctrl: assert property ($rose(resetn) |-> busCtrlHigh == 8'hd0 && busCtrlLow == 8'h3c)
        else $error("bus control reset value");
    chk_standby_ctrl: assert property ($rose(hardwareStandbyn) |-> busCtrlHigh == 8'hd0 && busCtrlLow == 8'h3c)
        else $error("bus control standby value");
    chk_read_lanes: assert property (rdPend |-> (hrdata & 32'hffff_ff00) == 32'h0000_0000)
        else $error("read data outside its lane");
    chk_unmapped_zero: assert property (rdPend && !rdMapped |-> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    cover property (rdPend && !rdMapped);
    cover property (waitRequestAccepted);
    cover property (accessInternal);
    cover property ($rose(hardwareStandbyn));
endmodule : eabc_regs_monitor
bind eabc_regs eabc_regs_monitor u_eabc_regs_monitor (.clock(clock), .resetn(resetn),
    .hardwareStandbyn(hardwareStandbyn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .accessInternal(accessInternal), .extWaitRequest(extWaitRequest), .areaByteWide(areaByteWide),
    .areaThreeState(areaThreeState), .areaWaitCount(areaWaitCount),
    .waitRequestAccepted(waitRequestAccepted), .busCtrlHigh(busCtrlHigh), .busCtrlLow(busCtrlLow));
`default_nettype wire

//--- tb.sv
// testbench: register bank, reset values and per-area shaping
`timescale 1ns/1ps
`default_nettype none
module tb;
    import eabc_pkg::*;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        hardwareStandbyn = 1'b1;
    logic [2:0]  operatingMode = 3'h5;
    logic        normalMode = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [2:0]  accessArea = 3'h0;
    logic        accessInternal = 1'b0;
    logic        extWaitRequest = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, areaByteWide, areaThreeState, waitRequestAccepted;
    logic [1:0]  areaWaitCount;
    logic [7:0]  busCtrlHigh, busCtrlLow;
    int          nErrors = 0;
    int          totalChecks = 0;
    eabc_regs u_eabc_regs (.clock(clock), .resetn(resetn), .hardwareStandbyn(hardwareStandbyn),
        .operatingMode(operatingMode), .normalMode(normalMode), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .accessArea(accessArea),
        .accessInternal(accessInternal), .extWaitRequest(extWaitRequest),
        .areaByteWide(areaByteWide), .areaThreeState(areaThreeState), .areaWaitCount(areaWaitCount),
        .waitRequestAccepted(waitRequestAccepted), .busCtrlHigh(busCtrlHigh), .busCtrlLow(busCtrlLow));
    // 40 MHz clock
    initial forever #12.5 clock = ~clock;
    task automatic endOfTest();
        if (nErrors == 0 && totalChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : endOfTest
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        totalChecks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            nErrors++;
        end
    endtask : check
    // one single word transfer, register byte in lane 0
    task automatic xfer(input logic [15:0] a, input logic w, input logic [7:0] wd,
                        output logic [7:0] rd);
        haddr  <= {14'h0000, a, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsel   <= 1'b1;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, wd};
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata[7:0];
    endtask : xfer
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] unused;
        xfer(a, 1'b1, d, unused);
    endtask : wr
    task automatic rdChk(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] got;
        xfer(a, 1'b0, 8'h00, got);
        check($sformatf("register %h", a), exp, got);
    endtask : rdChk
    task automatic checkResetValues(input logic [7:0] widthExp);
        logic [7:0] exp [6];
        exp = '{widthExp, 8'hff, 8'hff, 8'hff, 8'hd0, 8'h3c};
        for (int i = 0; i < 6; i++) rdChk(ADDR_AREA_BUS_WIDTH_CTRL + 16'(i), exp[i]);
    endtask : checkResetValues
    // power-on reset in operating modes 1 to 7
    task automatic testResetModes();
        for (int m = 1; m < 8; m++) begin
            operatingMode <= 3'(m);
            resetn        <= 1'b0;
            repeat (10) @(posedge clock);
            resetn <= 1'b1;
            @(posedge clock);
            checkResetValues((m == 4) ? 8'h00 : 8'hff);
        end
    endtask : testResetModes
    // write then read back, unmapped reads, hardware standby
    task automatic testRegsAndStandby();
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_AREA_BUS_WIDTH_CTRL + 16'(i), 8'ha5 ^ 8'(i * 17));
            rdChk(ADDR_AREA_BUS_WIDTH_CTRL + 16'(i), 8'ha5 ^ 8'(i * 17));
        end
        rdChk(16'hfed6, 8'h00);
        rdChk(16'hfed7, 8'h00);
        hardwareStandbyn <= 1'b0;
        repeat (2) @(posedge clock);
        hardwareStandbyn <= 1'b1;
        @(posedge clock);
        checkResetValues(8'hff);
    endtask : testRegsAndStandby
    // every area in advanced mode, normal mode and internal space
    task automatic testAreas();
        logic [15:0] waits;
        logic [7:0]  widths;
        logic [7:0]  states;
        int          ea;
        logic        ts;
        waits  = 16'he41b;
        widths = 8'h5a;
        states = 8'h3d;
        wr(ADDR_AREA_BUS_WIDTH_CTRL, widths);
        wr(ADDR_AREA_ACCESS_STATE_CTRL, states);
        wr(ADDR_AREA_WAIT_COUNT_HIGH, waits[15:8]);
        wr(ADDR_AREA_WAIT_COUNT_LOW, waits[7:0]);
        for (int k = 0; k < 24; k++) begin
            accessArea     <= 3'(k);
            normalMode     <= k[3];
            accessInternal <= k[4];
            @(posedge clock);
            ea = k[3] ? 0 : k % 8;
            ts = !k[4] && states[ea];
            check("areaByteWide", 8'(!k[4] && widths[ea]), 8'(areaByteWide));
            check("areaThreeState", 8'(ts), 8'(areaThreeState));
            check("areaWaitCount", ts ? 8'(waits[2 * ea +: 2]) : 8'h00, 8'(areaWaitCount));
        end
    endtask : testAreas
    // wait pin honoured on a three-state area only
    task automatic testWaitPin();
        accessArea     <= 3'h0;
        accessInternal <= 1'b0;
        extWaitRequest <= 1'b1;
        repeat (2) @(posedge clock);
        #1 check("waitRequestAccepted", 8'h00, 8'(waitRequestAccepted));
        @(posedge clock);
        #1 check("waitRequestAccepted", 8'h01, 8'(waitRequestAccepted));
        accessArea <= 3'h1;
        repeat (2) @(posedge clock);
        #1 check("waitRequestAccepted", 8'h00, 8'(waitRequestAccepted));
        extWaitRequest <= 1'b0;
    endtask : testWaitPin
    initial begin
        testResetModes();
        testRegsAndStandby();
        testAreas();
        testWaitPin();
        endOfTest();
    end
    // watchdog against a hung transfer
    initial begin
        repeat (5000) @(posedge clock);
        nErrors++;
        endOfTest();
    end
endmodule : tb
`default_nettype wire
